// file: rtl/bsc_top.sv
// Debug breakpoint status and control registers with their event updates
`timescale 1ns/1ps
`include "bsc_map.svh"

module bsc_top (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire bsc_pkg::bsc_req_s  dr_req,
  output bsc_pkg::bsc_rsp_s       dr_rsp,
  input  wire logic               long_mode,
  input  wire logic               mode64,
  input  wire logic               debug_extensions_on,
  input  wire bsc_pkg::bsc_ref_s  ref_in,
  input  wire logic               bp_event,
  input  wire logic               single_step_trap_flag,
  input  wire logic               step_event,
  input  wire logic               hw_task_switch,
  input  wire logic               task_trap_event,
  input  wire logic               handler_entry,
  output logic                    debug_exception,
  output bsc_pkg::bsc_cause_e     db_cause,
  output bsc_pkg::bsc_ctrl_s      ctrl_out,
  output bsc_pkg::bsc_stat_s      stat_out
);

  bsc_pkg::bsc_state_s state_ff;
  bsc_pkg::bsc_state_s nxt_state;
  logic [3:0]          hit;
  logic [63:0]         stat_word;
  logic [63:0]         ctrl_word;
  logic                sel_stat;
  logic                sel_ctrl;
  logic                sel_alias;
  logic                upper_dirty;
  logic                gd_hit;
  logic                step_hit;
  logic                move_ok;

  // Comparator qualification lives apart so the pipe can reuse it per reference
  bsc_hit_unit u_hit (
    .ctrl                (state_ff.ctrl),
    .ref_in              (ref_in),
    .long_mode           (long_mode),
    .debug_extensions_on (debug_extensions_on),
    .hit                 (hit)
  );

  // Status read image: reserved ones fixed, bit 12 and upper half zero
  always_comb begin
    stat_word = `BSC_S_RSVD_ONES;
    stat_word[`BSC_S_HIT_LSB +: 4] = state_ff.stat.comparator_hit_flags;
    stat_word[`BSC_S_BD] = state_ff.stat.dbg_reg_access_flag;
    stat_word[`BSC_S_BS] = state_ff.stat.single_step_flag;
    stat_word[`BSC_S_BT] = state_ff.stat.task_switch_flag;
  end

  // Control read image: reserved zeros, bit 10 always one
  always_comb begin
    ctrl_word = `BSC_C_RSVD_ONES;
    for (int i = 0; i < 4; i++) begin
      ctrl_word[`BSC_C_L0 + `BSC_C_EN_STRIDE * i]     = state_ff.ctrl.bp_local_enable[i];
      ctrl_word[`BSC_C_L0 + `BSC_C_EN_STRIDE * i + 1] = state_ff.ctrl.bp_global_enable[i];
      ctrl_word[`BSC_C_RW0_LSB + `BSC_C_FIELD_STRIDE * i +: 2] = state_ff.ctrl.bp_access_type[i];
      ctrl_word[`BSC_C_LEN0_LSB + `BSC_C_FIELD_STRIDE * i +: 2] = state_ff.ctrl.bp_range_size[i];
    end
    ctrl_word[`BSC_C_LE] = state_ff.ctrl.exact_local;
    ctrl_word[`BSC_C_GE] = state_ff.ctrl.exact_global;
    ctrl_word[`BSC_C_GD] = state_ff.ctrl.reg_access_trap_enable;
  end

  // Request decode; the two low alias numbers fall onto status and control
  assign sel_alias   = (dr_req.num == `BSC_DR_ALIAS_STAT) || (dr_req.num == `BSC_DR_ALIAS_CTRL);
  assign sel_stat    = (dr_req.num == `BSC_DR_STAT) || (dr_req.num == `BSC_DR_ALIAS_STAT);
  assign sel_ctrl    = (dr_req.num == `BSC_DR_CTRL) || (dr_req.num == `BSC_DR_ALIAS_CTRL);
  assign upper_dirty = mode64 && (dr_req.wdata[`BSC_UPPER_LSB +: 32] != `BSC_UPPER_ZERO);

  // Trap enable intercepts every debug register move before it executes
  assign gd_hit   = dr_req.valid && state_ff.ctrl.reg_access_trap_enable;
  assign step_hit = step_event && single_step_trap_flag;
  assign move_ok  = dr_req.valid && !gd_hit && !(sel_alias && debug_extensions_on) &&
                    !(dr_req.write && upper_dirty && (sel_stat || sel_ctrl));

  // Next state: software moves first, hardware events after so a hardware event beats a software write
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rsp.ack      = dr_req.valid;
    nxt_state.rsp.gp_fault = 1'b0;
    nxt_state.rsp.ud_fault = 1'b0;
    nxt_state.rsp.gd_trap  = 1'b0;
    nxt_state.rsp.rdata    = 64'h0000_0000_0000_0000;
    nxt_state.db_exc       = 1'b0;
    nxt_state.cause        = bsc_pkg::BSC_CAUSE_NONE;

    // Alias numbers are illegal once the debug extensions are on
    if (dr_req.valid && !gd_hit && sel_alias && debug_extensions_on) begin
      nxt_state.rsp.ud_fault = 1'b1;
    end

    // Upper half is reserved in 64-bit mode; a set bit faults and nothing is stored
    if (dr_req.valid && !gd_hit && !(sel_alias && debug_extensions_on) && dr_req.write &&
        upper_dirty && (sel_stat || sel_ctrl)) begin
      nxt_state.rsp.gp_fault = 1'b1;
    end

    // Reads return the low half only; the upper half is always zero
    if (move_ok && !dr_req.write) begin
      if (sel_stat) begin
        nxt_state.rsp.rdata = stat_word;
      end else if (sel_ctrl) begin
        nxt_state.rsp.rdata = ctrl_word;
      end
    end

    // Status write: flag bits only, reserved bits ignored
    if (move_ok && dr_req.write && sel_stat) begin
      nxt_state.stat.comparator_hit_flags = dr_req.wdata[`BSC_S_HIT_LSB +: 4];
      nxt_state.stat.dbg_reg_access_flag  = dr_req.wdata[`BSC_S_BD];
      nxt_state.stat.single_step_flag     = dr_req.wdata[`BSC_S_BS];
      nxt_state.stat.task_switch_flag     = dr_req.wdata[`BSC_S_BT];
    end

    // Control write: each comparator takes its own fields
    if (move_ok && dr_req.write && sel_ctrl) begin
      for (int i = 0; i < 4; i++) begin
        nxt_state.ctrl.bp_local_enable[i]  = dr_req.wdata[`BSC_C_L0 + `BSC_C_EN_STRIDE * i];
        nxt_state.ctrl.bp_global_enable[i] = dr_req.wdata[`BSC_C_L0 + `BSC_C_EN_STRIDE * i + 1];
        nxt_state.ctrl.bp_access_type[i] =
          dr_req.wdata[`BSC_C_RW0_LSB + `BSC_C_FIELD_STRIDE * i +: 2];
        nxt_state.ctrl.bp_range_size[i] =
          dr_req.wdata[`BSC_C_LEN0_LSB + `BSC_C_FIELD_STRIDE * i +: 2];
      end
      // Exact bits are kept for software only and steer nothing
      nxt_state.ctrl.exact_local            = dr_req.wdata[`BSC_C_LE];
      nxt_state.ctrl.exact_global           = dr_req.wdata[`BSC_C_GE];
      nxt_state.ctrl.reg_access_trap_enable = dr_req.wdata[`BSC_C_GD];
    end

    // Hardware task switch drops the per-task arming, globals stay
    if (hw_task_switch) begin
      nxt_state.ctrl.bp_local_enable = 4'h0;
    end

    // Handler entry disarms the trap so the handler may touch the registers
    if (handler_entry) begin
      nxt_state.ctrl.reg_access_trap_enable = 1'b0;
    end

    // Breakpoint or general-detect event rewrites every hit flag, set or clear
    if (bp_event || gd_hit) begin
      nxt_state.stat.comparator_hit_flags = hit;
    end

    // Trapped move: flag set, move suppressed, exception raised
    if (gd_hit) begin
      nxt_state.stat.dbg_reg_access_flag = 1'b1;
      nxt_state.rsp.gd_trap              = 1'b1;
    end

    // Sticky flags: only set here, never cleared by hardware
    if (step_hit) begin
      nxt_state.stat.single_step_flag = 1'b1;
    end
    if (task_trap_event) begin
      nxt_state.stat.task_switch_flag = 1'b1;
    end

    // One exception, cause by priority; flags of lower causes are still recorded
    nxt_state.db_exc = step_hit || gd_hit || task_trap_event || bp_event;
    if (step_hit) begin
      nxt_state.cause = bsc_pkg::BSC_CAUSE_STEP;
    end else if (gd_hit) begin
      nxt_state.cause = bsc_pkg::BSC_CAUSE_REG_ACCESS;
    end else if (task_trap_event) begin
      nxt_state.cause = bsc_pkg::BSC_CAUSE_TASK;
    end else if (bp_event) begin
      nxt_state.cause = bsc_pkg::BSC_CAUSE_BREAKPOINT;
    end
  end

  // Single state register; reset leaves all flags and enables clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff.stat.comparator_hit_flags <= `BSC_S_RESET_FLAGS;
      state_ff.stat.dbg_reg_access_flag  <= 1'b0;
      state_ff.stat.single_step_flag     <= 1'b0;
      state_ff.stat.task_switch_flag     <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        state_ff.ctrl.bp_range_size[i]  <= `BSC_C_RESET_FIELD;
        state_ff.ctrl.bp_access_type[i] <= `BSC_C_RESET_FIELD;
      end
      state_ff.ctrl.reg_access_trap_enable <= 1'b0;
      state_ff.ctrl.exact_global           <= 1'b0;
      state_ff.ctrl.exact_local            <= 1'b0;
      state_ff.ctrl.bp_global_enable       <= 4'h0;
      state_ff.ctrl.bp_local_enable        <= 4'h0;
      state_ff.rsp.ack                     <= 1'b0;
      state_ff.rsp.gp_fault                <= 1'b0;
      state_ff.rsp.ud_fault                <= 1'b0;
      state_ff.rsp.gd_trap                 <= 1'b0;
      state_ff.rsp.rdata                   <= 64'h0000_0000_0000_0000;
      state_ff.db_exc                      <= 1'b0;
      state_ff.cause                       <= bsc_pkg::BSC_CAUSE_NONE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // All outputs straight from the state register
  assign dr_rsp          = state_ff.rsp;
  assign debug_exception = state_ff.db_exc;
  assign db_cause        = state_ff.cause;
  assign ctrl_out        = state_ff.ctrl;
  assign stat_out        = state_ff.stat;

endmodule

// file: rtl/bsc_map.svh
// Bit positions, reset images and encodings of the breakpoint status and control registers
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// Status register layout
`define BSC_S_HIT_LSB      0
`define BSC_S_BD           13
`define BSC_S_BS           14
`define BSC_S_BT           15
`define BSC_S_RSVD_ONES    64'h0000_0000_ffff_0ff0
`define BSC_S_RESET_FLAGS  4'h0

// Control register layout
`define BSC_C_L0           0
`define BSC_C_EN_STRIDE    2
`define BSC_C_LE           8
`define BSC_C_GE           9
`define BSC_C_GD           13
`define BSC_C_RW0_LSB      16
`define BSC_C_LEN0_LSB     18
`define BSC_C_FIELD_STRIDE 4
`define BSC_C_RSVD_ONES    64'h0000_0000_0000_0400
`define BSC_C_RESET_FIELD  2'h0

// Upper half of either register
`define BSC_UPPER_LSB      32
`define BSC_UPPER_ZERO     32'h0000_0000

// Debug register numbers
`define BSC_DR_LAST_ADDR   3'h3
`define BSC_DR_ALIAS_STAT  3'h4
`define BSC_DR_ALIAS_CTRL  3'h5
`define BSC_DR_STAT        3'h6
`define BSC_DR_CTRL        3'h7

// Access-type encodings
`define BSC_RW_EXEC        2'h0
`define BSC_RW_WRITE       2'h1
`define BSC_RW_IO          2'h2
`define BSC_RW_DATA        2'h3

// Range-length encodings, as kept-address-bit masks on the low three bits
`define BSC_LEN_1B         2'h0
`define BSC_LEN_2B         2'h1
`define BSC_LEN_8B         2'h2
`define BSC_LEN_4B         2'h3
`define BSC_KEEP_1B        3'h7
`define BSC_KEEP_2B        3'h6
`define BSC_KEEP_4B        3'h4
`define BSC_KEEP_8B        3'h0

`endif

// file: rtl/bsc_pkg.sv
// Types shared by the breakpoint status and control block
package bsc_pkg;

  // Kind of the memory or I/O reference presented to the comparators
  typedef enum logic [1:0] {BSC_ACC_EXEC, BSC_ACC_READ, BSC_ACC_WRITE, BSC_ACC_IO} bsc_acc_e;

  // Cause reported with a debug exception, highest priority first
  typedef enum logic [2:0] {BSC_CAUSE_NONE, BSC_CAUSE_STEP, BSC_CAUSE_REG_ACCESS, BSC_CAUSE_TASK,
                            BSC_CAUSE_BREAKPOINT} bsc_cause_e;

  typedef struct packed {
    logic [3:0][1:0] bp_range_size;
    logic [3:0][1:0] bp_access_type;
    logic            reg_access_trap_enable;
    logic            exact_global;
    logic            exact_local;
    logic [3:0]      bp_global_enable;
    logic [3:0]      bp_local_enable;
  } bsc_ctrl_s;

  typedef struct packed {
    logic       task_switch_flag;
    logic       single_step_flag;
    logic       dbg_reg_access_flag;
    logic [3:0] comparator_hit_flags;
  } bsc_stat_s;

  // Debug register move request from the execution pipe
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  num;
    logic [63:0] wdata;
  } bsc_req_s;

  // Answer to a debug register move
  typedef struct packed {
    logic        ack;
    logic        gp_fault;
    logic        ud_fault;
    logic        gd_trap;
    logic [63:0] rdata;
  } bsc_rsp_s;

  // Reference presented to the four comparators
  typedef struct packed {
    bsc_acc_e        kind;
    logic [2:0]      acc_lo;
    logic [3:0][2:0] cmp_lo;
    logic [3:0]      hi_match;
  } bsc_ref_s;

  typedef struct packed {
    bsc_stat_s  stat;
    bsc_ctrl_s  ctrl;
    bsc_rsp_s   rsp;
    logic       db_exc;
    bsc_cause_e cause;
  } bsc_state_s;

endpackage

// file: rtl/bsc_hit_unit.sv
// Per-comparator qualification of address matches by enable, access type and range length
`timescale 1ns/1ps
`include "bsc_map.svh"

module bsc_hit_unit (
  input  wire bsc_pkg::bsc_ctrl_s ctrl,
  input  wire bsc_pkg::bsc_ref_s  ref_in,
  input  wire logic               long_mode,
  input  wire logic               debug_extensions_on,
  output logic [3:0]              hit
);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      logic [2:0] keep;
      logic       type_ok;
      // Range length masks the low address bits out of the compare
      always_comb begin
        case (ctrl.bp_range_size[gi])
          `BSC_LEN_1B: keep = `BSC_KEEP_1B;
          `BSC_LEN_2B: keep = `BSC_KEEP_2B;
          `BSC_LEN_4B: keep = `BSC_KEEP_4B;
          `BSC_LEN_8B: keep = long_mode ? `BSC_KEEP_8B : `BSC_KEEP_1B; // Undefined outside long mode
          default:     keep = `BSC_KEEP_1B;
        endcase
      end
      // I/O type never matches unless the debug extensions are on
      always_comb begin
        case (ctrl.bp_access_type[gi])
          `BSC_RW_EXEC:  type_ok = (ref_in.kind == bsc_pkg::BSC_ACC_EXEC);
          `BSC_RW_WRITE: type_ok = (ref_in.kind == bsc_pkg::BSC_ACC_WRITE);
          `BSC_RW_IO:    type_ok = debug_extensions_on && (ref_in.kind == bsc_pkg::BSC_ACC_IO);
          `BSC_RW_DATA:  type_ok = (ref_in.kind == bsc_pkg::BSC_ACC_READ) ||
                                   (ref_in.kind == bsc_pkg::BSC_ACC_WRITE);
          default:       type_ok = 1'b0;
        endcase
      end
      // Each comparator armed by its own local or global enable
      assign hit[gi] = (ctrl.bp_local_enable[gi] | ctrl.bp_global_enable[gi]) && ref_in.hi_match[gi] &&
                       (((ref_in.acc_lo ^ ref_in.cmp_lo[gi]) & keep) == 3'h0) && type_ok;
    end
  endgenerate

endmodule

// file: tb/bsc_checker.sv
// Concurrent checks on the breakpoint status and control block ports
`timescale 1ns/1ps
module bsc_checker (
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire bsc_pkg::bsc_req_s   dr_req,
  input wire bsc_pkg::bsc_rsp_s   dr_rsp,
  input wire logic                mode64,
  input wire logic                single_step_trap_flag,
  input wire logic                step_event,
  input wire logic                hw_task_switch,
  input wire logic                task_trap_event,
  input wire logic                handler_entry,
  input wire logic                debug_exception,
  input wire bsc_pkg::bsc_cause_e db_cause,
  input wire bsc_pkg::bsc_ctrl_s  ctrl_out,
  input wire bsc_pkg::bsc_stat_s  stat_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Move steps: request taken under trap enable, then the trap answer
  sequence s_trapped; dr_req.valid && ctrl_out.reg_access_trap_enable; endsequence
  sequence s_gd_answer; dr_rsp.gd_trap && debug_exception && db_cause == bsc_pkg::BSC_CAUSE_REG_ACCESS; endsequence
  sequence s_sw_write; dr_req.valid && dr_req.write; endsequence
  // A concurrent step outranks the trap cause, so it is left out here
  property p_gd_trap; s_trapped ##0 !(step_event && single_step_trap_flag)
    |=> s_gd_answer ##0 stat_out.dbg_reg_access_flag; endproperty
  a_gd_trap: assert property (p_gd_trap) else $error("trapped move not answered by trap");
  property p_step; step_event && single_step_trap_flag |=> stat_out.single_step_flag && debug_exception
    && db_cause == bsc_pkg::BSC_CAUSE_STEP; endproperty
  a_step: assert property (p_step) else $error("step exception missing or outranked");
  property p_task; task_trap_event |=> stat_out.task_switch_flag && debug_exception; endproperty
  a_task: assert property (p_task) else $error("task flag not set");
  // Sticky flags only fall after a software write
  property p_keep_flags; |($past(stat_out[6:4]) & ~stat_out[6:4]) |-> $past(dr_req.valid && dr_req.write); endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("status flag cleared by hardware");
  property p_local_clear; hw_task_switch |=> ctrl_out.bp_local_enable == 4'h0; endproperty
  a_local_clear: assert property (p_local_clear) else $error("local enables survive task switch");
  property p_global_keep; |($past(ctrl_out.bp_global_enable) & ~ctrl_out.bp_global_enable)
    |-> $past(dr_req.valid && dr_req.write); endproperty
  a_global_keep: assert property (p_global_keep) else $error("global enable cleared by hardware");
  property p_handler; handler_entry |=> !ctrl_out.reg_access_trap_enable; endproperty
  a_handler: assert property (p_handler) else $error("trap enable kept on handler entry");
  property p_rsvd_stat; dr_req.valid && !dr_req.write && dr_req.num == 3'h6 && !ctrl_out.reg_access_trap_enable
    |=> dr_rsp.ack && dr_rsp.rdata[31:16] == 16'hffff && dr_rsp.rdata[12:4] == 9'h0ff; endproperty
  a_rsvd_stat: assert property (p_rsvd_stat) else $error("status reserved bits wrong");
  property p_gp; s_sw_write ##0 (mode64 && dr_req.num[2:1] == 2'h3 && |dr_req.wdata[63:32]
    && !ctrl_out.reg_access_trap_enable) |=> dr_rsp.gp_fault; endproperty
  a_gp: assert property (p_gp) else $error("upper half write not faulted");
endmodule

bind bsc_top bsc_checker i_bsc_checker (.sys_clk(sys_clk), .nrst(nrst), .dr_req(dr_req), .dr_rsp(dr_rsp),
  .mode64(mode64), .single_step_trap_flag(single_step_trap_flag), .step_event(step_event),
  .hw_task_switch(hw_task_switch), .task_trap_event(task_trap_event), .handler_entry(handler_entry),
  .debug_exception(debug_exception), .db_cause(db_cause), .ctrl_out(ctrl_out), .stat_out(stat_out));

// file: tb/tb_top.sv
// Self-checking bench for the breakpoint status and control block
`timescale 1ns/1ps
module tb_top;
  logic                sys_clk, nrst, long_mode, mode64, dbg_ext, bp_event, ss_flag, step_event;
  logic                hw_task_switch, task_trap_event, handler_entry, debug_exception;
  bsc_pkg::bsc_req_s   dr_req;
  bsc_pkg::bsc_rsp_s   dr_rsp;
  bsc_pkg::bsc_ref_s   ref_in;
  bsc_pkg::bsc_cause_e db_cause;
  bsc_pkg::bsc_ctrl_s  ctrl_out;
  bsc_pkg::bsc_stat_s  stat_out;
  logic [63:0]         rd;
  logic [3:0]          flt;
  int                  mismatches, checks_done;

  bsc_top i_bsc_top (.sys_clk(sys_clk), .nrst(nrst), .dr_req(dr_req), .dr_rsp(dr_rsp), .long_mode(long_mode),
    .mode64(mode64), .debug_extensions_on(dbg_ext), .ref_in(ref_in), .bp_event(bp_event),
    .single_step_trap_flag(ss_flag), .step_event(step_event), .hw_task_switch(hw_task_switch),
    .task_trap_event(task_trap_event), .handler_entry(handler_entry), .debug_exception(debug_exception),
    .db_cause(db_cause), .ctrl_out(ctrl_out), .stat_out(stat_out));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register move; a gap cycle before it keeps valid from being driven twice at one edge
  task automatic mv(input logic w, input logic [2:0] n, input logic [63:0] d);
    @(negedge sys_clk);
    dr_req <= '{valid: 1'b1, write: w, num: n, wdata: d};
    @(posedge sys_clk);
    @(negedge sys_clk);
    dr_req.valid <= 1'b0;
    rd = dr_rsp.rdata;
    flt = {dr_rsp.ack, dr_rsp.gp_fault, dr_rsp.ud_fault, dr_rsp.gd_trap};
  endtask

  task automatic t_reset_vals;
    mv(1'b0, 3'h6, 64'h0); chk("status reset", 64'h0000_0000_ffff_0ff0, rd);
    mv(1'b0, 3'h7, 64'h0); chk("control reset", 64'h0000_0000_0000_0400, rd);
    // Alias number reaches status while the debug extensions are off
    mv(1'b0, 3'h4, 64'h0); chk("status alias", 64'h0000_0000_ffff_0ff0, rd);
  endtask

  task automatic t_ctrl_layout;
    // Trap enable kept clear so the read back is not intercepted
    mv(1'b1, 3'h7, 64'h0000_0000_ffff_cbff);
    mv(1'b0, 3'h7, 64'h0); chk("control reserved", 64'h0000_0000_ffff_07ff, rd);
    mv(1'b1, 3'h7, 64'h0000_0000_1b4e_0396);
    chk("range fields", 64'h27, ctrl_out.bp_range_size);
    chk("type fields", 64'h72, ctrl_out.bp_access_type);
    chk("enables", 64'h96, {ctrl_out.bp_global_enable, ctrl_out.bp_local_enable});
    mv(1'b0, 3'h7, 64'h0); chk("exact bits kept", 64'h0000_0000_1b4e_0796, rd);
  endtask

  task automatic t_upper;
    mode64 = 1'b1;
    mv(1'b1, 3'h7, 64'h0000_0001_0000_0000); chk("control upper fault", 64'hc, flt);
    mv(1'b1, 3'h6, 64'h8000_0000_0000_0000); chk("status upper fault", 64'hc, flt);
    mv(1'b0, 3'h7, 64'h0); chk("control unchanged", 64'h0000_0000_1b4e_0796, rd);
    mode64 = 1'b0;
    // Outside 64-bit mode the upper half is simply dropped
    mv(1'b1, 3'h7, 64'hffff_ffff_0000_0000); chk("no fault", 64'h8, flt);
    mv(1'b0, 3'h7, 64'h0); chk("upper ignored", 64'h0000_0000_0000_0400, rd);
  endtask

  // Comparators: 0 exec 1B, 1 write 2B, 2 I/O 1B, 3 data 4B, all global
  task automatic t_hits;
    bsc_pkg::bsc_acc_e kd[5] = '{bsc_pkg::BSC_ACC_EXEC, bsc_pkg::BSC_ACC_WRITE, bsc_pkg::BSC_ACC_IO,
                                 bsc_pkg::BSC_ACC_READ, bsc_pkg::BSC_ACC_READ};
    logic [2:0]  lo[5] = '{3'h3, 3'h5, 3'h0, 3'h5, 3'h5};
    logic [11:0] cm[5] = '{12'h6db, 12'h965, 12'h000, 12'h924, 12'h924};
    logic [3:0]  hm[5] = '{4'hf, 4'hf, 4'hf, 4'h7, 4'hf};
    logic [3:0]  hx[5] = '{4'h1, 4'ha, 4'h4, 4'h0, 4'h8};
    dbg_ext = 1'b1;
    mv(1'b1, 3'h7, 64'h0000_0000_f250_04aa);
    mv(1'b0, 3'h5, 64'h0); chk("alias refused", 64'ha, flt);
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk);
      ref_in <= '{kind: kd[i], acc_lo: lo[i], cmp_lo: cm[i], hi_match: hm[i]};
      bp_event <= 1'b1;
      @(negedge sys_clk);
      bp_event <= 1'b0;
      chk("hit flags", {60'h0, hx[i]}, stat_out.comparator_hit_flags);
      if (hx[i] != 4'h0) begin
        chk("break cause", {1'b1, bsc_pkg::BSC_CAUSE_BREAKPOINT}, {debug_exception, db_cause});
      end
    end
    // Eight-byte range on comparator 3 only takes effect in long mode
    mv(1'b1, 3'h7, 64'h0000_0000_b250_04aa);
    for (int j = 0; j < 2; j++) begin
      @(negedge sys_clk);
      long_mode <= (j == 1);
      ref_in.acc_lo <= 3'h0;
      bp_event <= 1'b1;
      @(negedge sys_clk);
      bp_event <= 1'b0;
      chk("eight byte range", (j == 1) ? 64'h8 : 64'h0, stat_out.comparator_hit_flags);
    end
  endtask

  task automatic t_events;
    @(negedge sys_clk);
    ss_flag <= 1'b0;
    step_event <= 1'b1;
    @(negedge sys_clk);
    chk("step refused", 64'h0, stat_out.single_step_flag);
    ss_flag <= 1'b1;
    task_trap_event <= 1'b1;
    bp_event <= 1'b1;
    @(negedge sys_clk);
    {step_event, task_trap_event, bp_event} <= 3'h0;
    chk("step first", {1'b1, bsc_pkg::BSC_CAUSE_STEP}, {debug_exception, db_cause});
    chk("flags together", 64'h68, stat_out);
    repeat (3) @(negedge sys_clk);
    chk("flags sticky", 64'h68, stat_out);
    mv(1'b0, 3'h6, 64'h0); chk("status image", 64'h0000_0000_ffff_cff8, rd);
    mv(1'b1, 3'h6, 64'h0); chk("software clear", 64'h0, stat_out);
  endtask

  task automatic t_gd;
    mv(1'b1, 3'h7, 64'h0000_0000_0000_20ff);
    mv(1'b0, 3'h6, 64'h0); chk("trap answer", 64'h9, flt);
    chk("no read data", 64'h0, rd);
    chk("trap cause", {1'b1, bsc_pkg::BSC_CAUSE_REG_ACCESS}, {debug_exception, db_cause});
    chk("access flag", 64'h1, stat_out.dbg_reg_access_flag);
    chk("enable held", 64'h1, ctrl_out.reg_access_trap_enable);
    @(negedge sys_clk);
    {handler_entry, hw_task_switch} <= 2'h3;
    @(negedge sys_clk);
    {handler_entry, hw_task_switch} <= 2'h0;
    chk("locals cleared", 64'h0, ctrl_out.bp_local_enable);
    chk("globals kept", 64'hf, ctrl_out.bp_global_enable);
    mv(1'b0, 3'h7, 64'h0); chk("control after handler", 64'h0000_0000_0000_04aa, rd);
  endtask

  task automatic final_report;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset held for twelve edges, then every scenario in turn
  initial begin
    {nrst, long_mode, mode64, dbg_ext, bp_event, ss_flag, step_event} = 7'h0;
    {hw_task_switch, task_trap_event, handler_entry} = 3'h0;
    dr_req = '0;
    ref_in = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst <= 1'b1;
    t_reset_vals();
    t_ctrl_layout();
    t_upper();
    t_hits();
    t_events();
    t_gd();
    final_report();
  end
endmodule
